//--- logic/axil_regslave.sv
/*
 AXI4-Lite slave front end: takes write address and data in either order,
 issues one write strobe to the core, and answers reads from the core decode.
 Assumes the core decodes addresses combinationally and raises the error
 flags for unmapped offsets.
*/
`timescale 1ns/1ps
`default_nettype none
module axil_regslave
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [modem_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [modem_pkg::ADDR_W-1:0]  araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	regbus_if.bus_side                         rb
);
	import modem_pkg::*;

	logic                aw_got_r;
	logic                w_got_r;
	logic [ADDR_W-1:0]   aw_addr_r;
	logic [31:0]         w_data_r;
	logic [3:0]          w_strb_r;

	// Each half is held until the other arrives and the answer is gone
	assign awready    = !aw_got_r && !bvalid;
	assign wready     = !w_got_r && !bvalid;
	assign arready    = !rvalid;
	assign rb.wr_en   = aw_got_r && w_got_r && !bvalid;
	assign rb.wr_addr = aw_addr_r;
	assign rb.wr_data = w_data_r;
	assign rb.wr_strb = w_strb_r;
	assign rb.rd_addr = araddr;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end
		else if (rb.wr_en)
		begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_got_r  <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (rb.wr_en)
		begin
			bvalid <= 1'b1;
			bresp  <= rb.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= rb.rd_data;
			rresp  <= rb.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rready)
			rvalid <= 1'b0;
	end
endmodule // axil_regslave
`default_nettype wire

//--- logic/modem_pkg.sv
/*
 Constants for the serial port modem control block: register byte offsets,
 control bit positions, reset values and bus response codes.
 Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
`default_nettype none
package modem_pkg;
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  OFF_MODEM_CTL  = 8'h04;
	localparam logic [7:0]  OFF_INT_STATUS = 8'h08;
	localparam logic [7:0]  OFF_INT_CLEAR  = 8'h0C;
	localparam logic [7:0]  OFF_INT_ENABLE = 8'h10;
	localparam logic [7:0]  OFF_LINE_STATE = 8'h14;

	localparam int          MCR_DTR        = 0;
	localparam int          MCR_RTS        = 1;
	localparam int          MCR_SPARE      = 2;
	localparam int          MCR_IRQ_GATE   = 3;
	localparam int          MCR_LOOP       = 4;
	localparam int          MCR_W          = 5;
	localparam logic [4:0]  MCR_RESET      = 5'h00;

	localparam int          EV_CTS         = 0;
	localparam int          EV_DSR         = 1;
	localparam int          EV_RI_END      = 2;
	localparam int          EV_DCD         = 3;
	localparam int          EV_W           = 4;
	localparam logic [3:0]  EV_RESET       = 4'h0;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : modem_pkg
`default_nettype wire

//--- logic/regbus_if.sv
/*
 Internal register access carrier between the bus slave and the block core.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface regbus_if;
	import modem_pkg::*;
	logic               wr_en;
	logic [ADDR_W-1:0]  wr_addr;
	logic [31:0]        wr_data;
	logic [3:0]         wr_strb;
	logic               wr_err;
	logic [ADDR_W-1:0]  rd_addr;
	logic [31:0]        rd_data;
	logic               rd_err;

	modport bus_side
	(
		output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input  wr_err, rd_data, rd_err
	);
	modport core_side
	(
		input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_err, rd_data, rd_err
	);
endinterface : regbus_if
`default_nettype wire

//--- logic/uart_modem_control.sv
/*
 Modem control part of a serial port: the modem control register, the
 handshake output pins, the interrupt output gate and diagnostic loopback,
 plus sticky modem-status events with an enable mask.
 Assumes the transmit and receive shift registers, line status and
 interrupt identification logic sit outside and meet this block through
 the serial and interrupt request ports; pin inputs are synchronous.
*/
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uart_modem_control
(
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [modem_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [31:0]                   wdata,
	input  wire logic [3:0]                    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [modem_pkg::ADDR_W-1:0]  araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [31:0]                        rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	input  wire logic                          tx_shift_out,
	output logic                               rx_shift_in,
	output logic                               txd,
	input  wire logic                          rxd,
	input  wire logic                          cts_n,
	input  wire logic                          dsr_n,
	input  wire logic                          ri_n,
	input  wire logic                          dcd_n,
	output logic                               dtr_n,
	output logic                               rts_n,
	output logic                               cts_state,
	output logic                               dsr_state,
	output logic                               ri_state,
	output logic                               dcd_state,
	input  wire logic                          uart_irq_req,
	output logic                               serial_irq_o,
	output logic                               serial_irq_oe,
	output logic                               irq
);
	import modem_pkg::*;

	regbus_if rb ();

	axil_regslave u_slave
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rb      (rb)
	);

	logic [MCR_W-1:0]  mcr_r;
	logic [EV_W-1:0]   ev_status_r;
	logic [EV_W-1:0]   ev_enable_r;
	logic [EV_W-1:0]   line_prev_r;
	logic [EV_W-1:0]   line_now;
	logic [EV_W-1:0]   ev_set;
	logic [EV_W-1:0]   ev_clr;
	logic              loop_on;
	logic              wr_low;
	logic              hit_mcr;
	logic              hit_clr;
	logic              hit_en;
	logic              ev_any;

	assign loop_on = mcr_r[MCR_LOOP];
	assign wr_low  = rb.wr_en && rb.wr_strb[0];
	assign hit_mcr = rb.wr_addr == OFF_MODEM_CTL;
	assign hit_clr = rb.wr_addr == OFF_INT_CLEAR;
	assign hit_en  = rb.wr_addr == OFF_INT_ENABLE;

	// Status is RO; writes to it are refused like an unmapped offset
	assign rb.wr_err = !(hit_mcr || hit_clr || hit_en);

	// Only the five defined control bits are stored; bits 7:5 are dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mcr_r <= MCR_RESET;
		else if (wr_low && hit_mcr)
			mcr_r <= rb.wr_data[MCR_W-1:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ev_enable_r <= EV_RESET;
		else if (wr_low && hit_en)
			ev_enable_r <= rb.wr_data[EV_W-1:0];
	end

	// Status seen by the modem status logic; active high means asserted.
	// In loopback the pins are cut off and the control bits stand in.
	always_comb
	begin
		if (loop_on)
		begin
			line_now[EV_CTS] = mcr_r[MCR_RTS];
			line_now[EV_DSR] = mcr_r[MCR_DTR];
			line_now[EV_RI_END] = mcr_r[MCR_SPARE];
			line_now[EV_DCD] = mcr_r[MCR_IRQ_GATE];
		end
		else
		begin
			line_now[EV_CTS] = !cts_n;
			line_now[EV_DSR] = !dsr_n;
			line_now[EV_RI_END] = !ri_n;
			line_now[EV_DCD] = !dcd_n;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			line_prev_r <= EV_RESET;
		else
			line_prev_r <= line_now;
	end

	// Change events; ring counts only when the indicator goes away.
	// Loopback events come from the control bits, so software can test
	// the interrupt path without a modem attached.
	always_comb
	begin
		ev_set = line_now ^ line_prev_r;
		ev_set[EV_RI_END] = line_prev_r[EV_RI_END] && !line_now[EV_RI_END];
		ev_clr = (wr_low && hit_clr) ? rb.wr_data[EV_W-1:0] : EV_RESET;
	end

	// A new event in the clearing cycle survives the clear
	genvar gi;
	generate
		for (gi = 0; gi < EV_W; gi++)
		begin : g_ev
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					ev_status_r[gi] <= 1'b0;
				else if (ev_set[gi])
					ev_status_r[gi] <= 1'b1;
				else if (ev_clr[gi])
					ev_status_r[gi] <= 1'b0;
			end
		end
	endgenerate

	assign ev_any = |(ev_status_r & ev_enable_r);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= ev_any;
	end

	// Interrupt pin: the request is driven only while the gate bit is 1;
	// otherwise the pin is released. Loopback does not disturb this path.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_irq_o  <= 1'b0;
			serial_irq_oe <= 1'b0;
		end
		else
		begin
			serial_irq_o  <= uart_irq_req || ev_any;
			serial_irq_oe <= mcr_r[MCR_IRQ_GATE];
		end
	end

	// Handshake pins are active low; loopback parks them inactive high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
		end
		else if (loop_on)
		begin
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
		end
		else
		begin
			dtr_n <= !mcr_r[MCR_DTR];
			rts_n <= !mcr_r[MCR_RTS];
		end
	end

	// Serial data path. One register stage on each leg costs a clock of
	// delay, far below a bit time, and keeps the pins glitch free.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			txd         <= 1'b1;
			rx_shift_in <= 1'b1;
		end
		else if (loop_on)
		begin
			txd         <= 1'b1;
			rx_shift_in <= tx_shift_out;
		end
		else
		begin
			txd         <= tx_shift_out;
			rx_shift_in <= rxd;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cts_state <= 1'b0;
			dsr_state <= 1'b0;
			ri_state  <= 1'b0;
			dcd_state <= 1'b0;
		end
		else
		begin
			cts_state <= line_now[EV_CTS];
			dsr_state <= line_now[EV_DSR];
			ri_state  <= line_now[EV_RI_END];
			dcd_state <= line_now[EV_DCD];
		end
	end

	// Read decode; the clear register is write only and reads as zero
	always_comb
	begin
		rb.rd_data = 32'h0000_0000;
		rb.rd_err  = 1'b0;
		case (rb.rd_addr)
			OFF_MODEM_CTL:  rb.rd_data[MCR_W-1:0] = mcr_r;
			OFF_INT_STATUS: rb.rd_data[EV_W-1:0] = ev_status_r;
			OFF_INT_CLEAR:  rb.rd_data = 32'h0000_0000;
			OFF_INT_ENABLE: rb.rd_data[EV_W-1:0] = ev_enable_r;
			OFF_LINE_STATE: rb.rd_data[EV_W-1:0] = line_now;
			default:        rb.rd_err = 1'b1;
		endcase
	end
endmodule // uart_modem_control
`default_nettype wire

//--- tb/modem_partner.sv
/*
 Modem on the far side of the serial pins: echoes the handshake lines back.
 Assumes the bench clock; pins change only after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module modem_partner
(
	input  wire logic aclk,
	input  wire logic txd,
	input  wire logic dtr_n,
	input  wire logic rts_n,
	output var logic  rxd,
	output var logic  cts_n,
	output var logic  dsr_n,
	output var logic  ri_n,
	output var logic  dcd_n
);
	initial
	begin
		{rxd, cts_n, dsr_n, ri_n, dcd_n} = 5'h1F;
	end
	// Inverse of our line, so a receiver that still listens here sees wrong bits
	always @(posedge aclk)
	begin
		rxd   <= ~txd;
		cts_n <= rts_n;
		dsr_n <= dtr_n;
		dcd_n <= dtr_n;
		// Rings while both handshake lines are asserted, so ring edges occur
		ri_n  <= dtr_n | rts_n;
	end
endmodule // modem_partner
`default_nettype wire

//--- tb/uart_modem_control_properties.sv
/*
 Port checker for the modem control block.
 Assumes modem_control changes only through bus writes to its offset.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_modem_control_properties
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        tx_shift_out,
	input wire logic        rx_shift_in,
	input wire logic        txd,
	input wire logic        rxd,
	input wire logic        cts_n,
	input wire logic        dsr_n,
	input wire logic        ri_n,
	input wire logic        dcd_n,
	input wire logic        dtr_n,
	input wire logic        rts_n,
	input wire logic        cts_state,
	input wire logic        dsr_state,
	input wire logic        ri_state,
	input wire logic        dcd_state,
	input wire logic        serial_irq_oe
);
	import modem_pkg::*;
	logic [7:0] aa_r, ra_r;
	logic [4:0] wd_r, m_r;
	logic       ws_r, bv_r, ok_r;
	// Shadow lands one edge after the real register, level with the outputs
	always_ff @(posedge aclk)
	begin
		ok_r <= aresetn;
		bv_r <= aresetn & bvalid;
		if (awvalid & awready)
			aa_r <= awaddr;
		if (wvalid & wready)
			{ws_r, wd_r} <= {wstrb[0], wdata[4:0]};
		if (arvalid & arready)
			ra_r <= araddr;
		if (!aresetn)
			m_r <= MCR_RESET;
		else if (bvalid & !bv_r & ws_r & (aa_r == OFF_MODEM_CTL))
			m_r <= wd_r;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ok_r);
	a_txd_path: assert property
		(txd == (m_r[4] | $past(tx_shift_out)))
		else $error("txd wrong");
	a_rx_source: assert property
		(rx_shift_in == (m_r[4] ? $past(tx_shift_out) : $past(rxd)))
		else $error("receive input from wrong source");
	a_pin_levels: assert property
		(dtr_n == !(m_r[0] & !m_r[4]) && rts_n == !(m_r[1] & !m_r[4]))
		else $error("handshake pins wrong");
	a_loop_status: assert property
		(m_r[4] |-> {dcd_state, ri_state, dsr_state, cts_state}
			== {m_r[3], m_r[2], m_r[0], m_r[1]})
		else $error("loopback status wrong");
	a_pin_status: assert property
		(!m_r[4] |-> {dcd_state, ri_state, dsr_state, cts_state}
			== ~$past({dcd_n, ri_n, dsr_n, cts_n}))
		else $error("pin status wrong");
	a_gate_oe: assert property
		(serial_irq_oe == m_r[3])
		else $error("irq enable wrong");
	a_upper_zero: assert property
		(rvalid |-> rdata[31:5] == 27'h0)
		else $error("upper bits set");
	a_read_back: assert property
		($rose(rvalid) && ra_r == OFF_MODEM_CTL |-> rdata[4:0] == m_r)
		else $error("control readback wrong");
endmodule // uart_modem_control_properties
bind uart_modem_control uart_modem_control_properties chk_inst (.aclk, .aresetn, .awaddr,
	.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready,
	.rdata, .rvalid, .tx_shift_out, .rx_shift_in, .txd, .rxd, .cts_n, .dsr_n, .ri_n, .dcd_n,
	.dtr_n, .rts_n, .cts_state, .dsr_state, .ri_state, .dcd_state, .serial_irq_oe);
`default_nettype wire

//--- tb/uart_modem_control_tb.sv
/*
 Testbench for the modem control block: AXI4-Lite tasks and directed tests.
 Assumes the echoing modem partner on the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_modem_control_tb;
	import modem_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, tx_shift_out, rx_shift_in, txd, rxd;
	logic        cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, cts_state, dsr_state, ri_state;
	logic        dcd_state, uart_irq_req, serial_irq_o, serial_irq_oe, irq;
	logic [7:0]  awaddr, araddr, pat;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          errors, checks, cyc;
	uart_modem_control uart_modem_control_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .tx_shift_out, .rx_shift_in, .txd, .rxd, .cts_n, .dsr_n,
		.ri_n, .dcd_n, .dtr_n, .rts_n, .cts_state, .dsr_state, .ri_state, .dcd_state,
		.uart_irq_req, .serial_irq_o, .serial_irq_oe, .irq);
	modem_partner modem_partner_inst (.aclk, .txd, .dtr_n, .rts_n, .rxd, .cts_n, .dsr_n, .ri_n,
		.dcd_n);
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic results;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ready is looked at on the falling edge so the rising edge never races it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w, b;
		logic [1:0] gr;
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, 4'h1};
		{awvalid, wvalid, bready} <= 3'b111;
		do
		begin
			@(negedge aclk);
			{aw, w, b, gr} = {awvalid & awready, wvalid & wready, bvalid, bresp};
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		chk({30'h0, gr}, {30'h0, r});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ar, rv;
		logic [31:0] got;
		logic [1:0] gr;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do
		begin
			@(negedge aclk);
			{ar, rv, got, gr} = {arvalid & arready, rvalid, rdata, rresp};
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
		chk(got, d);
		chk({30'h0, gr}, {30'h0, r});
	endtask
	task automatic irq_is(input logic e);
		for (int k = 0; k < 8 && irq !== e; k++)
			@(negedge aclk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			results();
		end
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, tx_shift_out, uart_irq_req} = 8'h0;
		{awaddr, araddr, wdata, wstrb, pat} = 60'h0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_MODEM_CTL, 32'h0, RESP_OKAY);
		chk({29'h0, dtr_n, rts_n, serial_irq_oe}, 32'h6);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_MODEM_CTL, 32'h1 << i, RESP_OKAY);
			rd(OFF_MODEM_CTL, 32'h1 << i, RESP_OKAY);
			chk({30'h0, dtr_n, rts_n}, {30'h0, i != 0, i != 1});
			chk({31'h0, serial_irq_oe}, {31'h0, i == 3});
		end
		wr(OFF_MODEM_CTL, 32'hFFFF_FFEF, RESP_OKAY);
		rd(OFF_MODEM_CTL, 32'h0F, RESP_OKAY);
		$display("test control bits done");
		wr(OFF_MODEM_CTL, 32'h1F, RESP_OKAY);
		@(negedge aclk);
		chk({29'h0, txd, dtr_n, rts_n}, 32'h7);
		chk({28'h0, dcd_state, ri_state, dsr_state, cts_state}, 32'hF);
		pat = 8'hA5;
		for (int j = 0; j < 2; j++)
		begin
			wr(OFF_MODEM_CTL, j ? 32'h10 : 32'h03, RESP_OKAY);
			for (int i = 0; i < 8; i++)
			begin
				tx_shift_out <= pat[i];
				@(posedge aclk);
				@(negedge aclk);
				chk({31'h0, txd}, {31'h0, j ? 1'b1 : pat[i]});
				if (j)
					chk({31'h0, rx_shift_in}, {31'h0, pat[i]});
				@(posedge aclk);
			end
		end
		$display("test loopback done");
		wr(OFF_INT_CLEAR, 32'hF, RESP_OKAY);
		wr(OFF_INT_ENABLE, 32'h1 << EV_CTS, RESP_OKAY);
		irq_is(1'b0);
		wr(OFF_MODEM_CTL, 32'h12, RESP_OKAY);
		irq_is(1'b1);
		chk({31'h0, serial_irq_o}, 32'h1);
		rd(OFF_INT_STATUS, 32'h1 << EV_CTS, RESP_OKAY);
		wr(OFF_INT_CLEAR, 32'hF, RESP_OKAY);
		irq_is(1'b0);
		wr(OFF_INT_ENABLE, 32'h0, RESP_OKAY);
		wr(OFF_MODEM_CTL, 32'h10, RESP_OKAY);
		rd(OFF_INT_STATUS, 32'h1 << EV_CTS, RESP_OKAY);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_INT_CLEAR, 32'hF, RESP_OKAY);
		wr(OFF_MODEM_CTL, 32'h14, RESP_OKAY);
		rd(OFF_LINE_STATE, 32'h1 << EV_RI_END, RESP_OKAY);
		rd(OFF_INT_STATUS, 32'h0, RESP_OKAY);
		wr(OFF_MODEM_CTL, 32'h10, RESP_OKAY);
		rd(OFF_INT_STATUS, 32'h1 << EV_RI_END, RESP_OKAY);
		uart_irq_req <= 1'b1;
		repeat (2) @(posedge aclk);
		chk({30'h0, irq, serial_irq_o}, 32'h1);
		uart_irq_req <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, serial_irq_o}, 32'h0);
		$display("test interrupts done");
		wr(OFF_MODEM_CTL, 32'h0B, RESP_OKAY);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_MODEM_CTL, 32'h0, RESP_OKAY);
		chk({29'h0, dtr_n, rts_n, serial_irq_oe}, 32'h6);
		$display("test reset done");
		wr(OFF_INT_STATUS, 32'hF, RESP_SLVERR);
		rd(8'h40, 32'h0, RESP_SLVERR);
		$display("test bus errors done");
		results();
	end
endmodule // uart_modem_control_tb
`default_nettype wire
